// ---- hdl/pio_ctrl_pkg.sv ----
// constants for the parallel port control word decoder
package pio_ctrl_pkg;
	// ------------------------------------------------------------
	// control word identification
	// ------------------------------------------------------------
	localparam logic [7:0] vector_id_mask   = 8'h01;
	localparam logic [7:0] vector_id_code   = 8'h00;
	localparam logic [7:0] word_id_mask     = 8'h0f;
	localparam logic [7:0] mode_id_code     = 8'h0f;
	localparam logic [7:0] int_ctrl_id_code = 8'h07;
	localparam logic [7:0] int_en_id_code   = 8'h03;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int mode_hi_bit    = 7;
	localparam int mode_lo_bit    = 6;
	localparam int int_en_bit     = 7;
	localparam int logic_sel_bit  = 6;
	localparam int level_sel_bit  = 5;
	localparam int mask_follows_bit = 4;
	// ------------------------------------------------------------
	// modes and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] mode_byte_out = 2'h0;
	localparam logic [1:0] mode_byte_in  = 2'h1;
	localparam logic [1:0] mode_byte_bid = 2'h2;
	localparam logic [1:0] mode_bit      = 2'h3;
	localparam logic [1:0] mode_reset    = 2'h1;
	localparam logic [7:0] vector_reset  = 8'h00;
	localparam logic [7:0] dir_reset     = 8'hff;
	localparam logic [7:0] mask_reset    = 8'hff;
	localparam logic [1:0] cond_reset    = 2'h0;
endpackage

// ---- hdl/pio_word_sequencer.sv ----
// tracks which follow-on control byte is expected next
`timescale 1ns/100ps
module pio_word_sequencer (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       wr_i,
	input  wire logic       set_dir_i,
	input  wire logic       set_mask_i,
	output logic            dir_next_o,
	output logic            mask_next_o
);
	typedef enum logic [1:0] {idle, want_dir, want_mask} seq_state_type;
	typedef struct packed {
		seq_state_type st;
	} seq_type;
	seq_type r;
	seq_type next_r;

	always_comb begin
		next_r = r;
		if (wr_i) begin
			case (r.st)
			want_dir: next_r.st = idle;
			want_mask: next_r.st = idle;
			idle: begin
				if (set_dir_i)
					next_r.st = want_dir;
				else if (set_mask_i)
					next_r.st = want_mask;
			end
			default: next_r.st = idle;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i)
			r <= '{st: idle};
		else
			r <= next_r;
	end

	assign dir_next_o  = (r.st == want_dir);
	assign mask_next_o = (r.st == want_mask);
endmodule

// ---- hdl/pio_int_condition.sv ----
// evaluates the and/or condition over unmasked input lines
`timescale 1ns/100ps
module pio_int_condition (
	input  wire logic [7:0] lines_i,
	input  wire logic [7:0] mask_i,
	input  wire logic [7:0] dir_i,
	input  wire logic       all_sel_i,
	input  wire logic       high_sel_i,
	output logic            cond_o
);
	logic [7:0] act;
	logic [7:0] watch;
	logic [7:0] hit;
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gen_line
			assign act[g]   = high_sel_i ? lines_i[g] : ~lines_i[g];
			assign watch[g] = ~mask_i[g] & dir_i[g];
			assign hit[g]   = watch[g] & act[g];
		end
	endgenerate
	assign cond_o = all_sel_i ? ((watch != 8'h00) && (hit == watch))
	                          : (hit != 8'h00);
endmodule

// ---- hdl/pio_port_control_word_decoder.sv ----
// per-port control word decoder with bit mode interrupt request
`timescale 1ns/100ps
module pio_port_control_word_decoder (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ctrl_wr_i,
	input  wire logic [7:0] ctrl_data_i,
	input  wire logic [7:0] port_lines_i,
	input  wire logic       int_clear_i,
	output logic [7:0]      interrupt_vector_o,
	output logic [1:0]      port_operating_mode_o,
	output logic [7:0]      line_direction_o,
	output logic [1:0]      interrupt_condition_control_o,
	output logic [7:0]      interrupt_line_mask_o,
	output logic            int_enable_o,
	output logic            int_pending_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] vector;
		logic [1:0] mode;
		logic [7:0] dir;
		logic [1:0] cond;
		logic [7:0] mask;
		logic       int_en;
		logic       pending;
		logic       cond_prev;
	} regs_type;
	regs_type r;
	regs_type next_r;

	logic dir_next;
	logic mask_next;
	logic is_vector;
	logic is_mode;
	logic is_int_ctrl;
	logic is_int_en;
	logic expect_follow;
	logic set_dir;
	logic set_mask;
	logic cond_now;
	logic cond_rise;
	logic       in_bit_mode;
	logic       pending_set;
	logic       pending_clear;
	logic [1:0] mode_field;
	logic [1:0] cond_field;
	logic       int_en_field;
	logic       mask_follows_field;
	logic       vector_we;
	logic       mode_we;
	logic       dir_we;
	logic       cond_we;
	logic       mask_we;
	logic       int_en_we;

	// ------------------------------------------------------------
	// word kinds
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		kind_none,
		kind_dir,
		kind_mask,
		kind_mode,
		kind_int_ctrl,
		kind_int_en,
		kind_vector
	} word_kind_type;
	word_kind_type word_kind;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	assign expect_follow = dir_next | mask_next;
	assign is_vector = ~expect_follow &&
		((ctrl_data_i & pio_ctrl_pkg::vector_id_mask) ==
		 pio_ctrl_pkg::vector_id_code);
	assign is_mode = ~expect_follow &&
		((ctrl_data_i & pio_ctrl_pkg::word_id_mask) ==
		 pio_ctrl_pkg::mode_id_code);
	assign is_int_ctrl = ~expect_follow &&
		((ctrl_data_i & pio_ctrl_pkg::word_id_mask) ==
		 pio_ctrl_pkg::int_ctrl_id_code);
	assign is_int_en = ~expect_follow &&
		((ctrl_data_i & pio_ctrl_pkg::word_id_mask) ==
		 pio_ctrl_pkg::int_en_id_code);
	assign set_dir = is_mode &&
		(ctrl_data_i[pio_ctrl_pkg::mode_hi_bit:pio_ctrl_pkg::mode_lo_bit]
		 == pio_ctrl_pkg::mode_bit);
	assign set_mask = is_int_ctrl &&
		ctrl_data_i[pio_ctrl_pkg::mask_follows_bit];

	// ------------------------------------------------------------
	// fields of the written byte
	// ------------------------------------------------------------
	assign mode_field = ctrl_data_i[pio_ctrl_pkg::mode_hi_bit:
		pio_ctrl_pkg::mode_lo_bit];
	assign cond_field = {ctrl_data_i[pio_ctrl_pkg::logic_sel_bit],
		ctrl_data_i[pio_ctrl_pkg::level_sel_bit]};
	assign int_en_field = ctrl_data_i[pio_ctrl_pkg::int_en_bit];
	assign mask_follows_field =
		ctrl_data_i[pio_ctrl_pkg::mask_follows_bit];

	// ------------------------------------------------------------
	// word kind, a follow-on byte before any command code
	// ------------------------------------------------------------
	assign word_kind = !ctrl_wr_i  ? kind_none     :
	                   dir_next    ? kind_dir      :
	                   mask_next   ? kind_mask     :
	                   is_mode     ? kind_mode     :
	                   is_int_ctrl ? kind_int_ctrl :
	                   is_int_en   ? kind_int_en   :
	                   is_vector   ? kind_vector   :
	                                 kind_none;

	// ------------------------------------------------------------
	// per register write enables
	// ------------------------------------------------------------
	assign vector_we = (word_kind == kind_vector);
	assign mode_we   = (word_kind == kind_mode);
	assign dir_we    = (word_kind == kind_dir);
	assign cond_we   = (word_kind == kind_int_ctrl);
	assign mask_we   = (word_kind == kind_mask);
	assign int_en_we = (word_kind == kind_int_ctrl) ||
		(word_kind == kind_int_en);

	// ------------------------------------------------------------
	// follow-on tracking and interrupt condition
	// ------------------------------------------------------------
	pio_word_sequencer i_pio_word_sequencer (
		.sys_clk_i   (sys_clk_i),
		.rst_n_i     (rst_n_i),
		.wr_i        (ctrl_wr_i),
		.set_dir_i   (set_dir),
		.set_mask_i  (set_mask),
		.dir_next_o  (dir_next),
		.mask_next_o (mask_next)
	);

	pio_int_condition i_pio_int_condition (
		.lines_i    (port_lines_i),
		.mask_i     (r.mask),
		.dir_i      (r.dir),
		.all_sel_i  (r.cond[1]),
		.high_sel_i (r.cond[0]),
		.cond_o     (cond_now)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	assign in_bit_mode = (r.mode == pio_ctrl_pkg::mode_bit);
	assign cond_rise   = cond_now && !r.cond_prev && in_bit_mode;

	// ------------------------------------------------------------
	// pending request
	// ------------------------------------------------------------
	assign pending_clear = int_clear_i ||
		(cond_we && mask_follows_field);
	assign pending_set = cond_rise && r.int_en;

	// ------------------------------------------------------------
	// register updates
	// ------------------------------------------------------------
	always_comb begin
		next_r           = r;
		next_r.cond_prev = cond_now;
		if (vector_we) begin
			next_r.vector = ctrl_data_i;
		end
		if (mode_we) begin
			next_r.mode = mode_field;
		end
		if (dir_we) begin
			next_r.dir = ctrl_data_i;
		end
		if (cond_we) begin
			next_r.cond = cond_field;
		end
		if (mask_we) begin
			next_r.mask = ctrl_data_i;
		end
		if (int_en_we) begin
			next_r.int_en = int_en_field;
		end
		if (pending_clear) begin
			next_r.pending = 1'b0;
		end
		// set wins over clear
		if (pending_set) begin
			next_r.pending = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			r.vector    <= pio_ctrl_pkg::vector_reset;
			r.mode      <= pio_ctrl_pkg::mode_reset;
			r.dir       <= pio_ctrl_pkg::dir_reset;
			r.cond      <= pio_ctrl_pkg::cond_reset;
			r.mask      <= pio_ctrl_pkg::mask_reset;
			r.int_en    <= 1'b0;
			r.pending   <= 1'b0;
			r.cond_prev <= 1'b0;
		end else
			r <= next_r;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign interrupt_vector_o            = r.vector;
	assign port_operating_mode_o         = r.mode;
	assign line_direction_o              = r.dir;
	assign interrupt_condition_control_o = r.cond;
	assign interrupt_line_mask_o         = r.mask;
	assign int_enable_o                  = r.int_en;
	assign int_pending_o                 = r.pending;
endmodule

// ---- dv/pio_host_model.sv ----
// host side model issuing control byte writes
`timescale 1ns/100ps
module pio_host_model (
	input  wire logic       sys_clk_i,
	output logic            ctrl_wr_o,
	output logic [7:0]      ctrl_data_o
);
	initial begin
		ctrl_wr_o = 1'b0;
		ctrl_data_o = 8'h00;
	end
	// follow-on bytes come right after their word, vector may be skipped
	task send(input logic [7:0] b);
		@(negedge sys_clk_i);
		ctrl_wr_o <= 1'b1;
		ctrl_data_o <= b;
	endtask
	// released bus shows the inverse of the last byte
	task idle;
		@(negedge sys_clk_i);
		ctrl_wr_o <= 1'b0;
		ctrl_data_o <= ~ctrl_data_o;
	endtask
endmodule

// ---- dv/pio_port_control_word_decoder_asserts.sv ----
// assertions for the control word decoder
`timescale 1ns/100ps
module pio_port_control_word_decoder_asserts (
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	input wire logic       ctrl_wr_i,
	input wire logic [7:0] ctrl_data_i,
	input wire logic [7:0] port_lines_i,
	input wire logic       int_clear_i,
	input wire logic [7:0] interrupt_vector_o,
	input wire logic [1:0] port_operating_mode_o,
	input wire logic [7:0] line_direction_o,
	input wire logic [1:0] interrupt_condition_control_o,
	input wire logic [7:0] interrupt_line_mask_o,
	input wire logic       int_enable_o,
	input wire logic       int_pending_o
);
	logic       dn;
	logic       mn;
	wire        w  = ctrl_wr_i & ~(dn | mn);
	wire  [7:0] d  = ctrl_data_i;
	wire  [3:0] lo = ctrl_data_i[3:0];
	wire        clr = int_clear_i | (w & (lo == 4'h7) & d[4]);
	// tracks the follow-on byte expected next
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			dn <= 1'b0;
			mn <= 1'b0;
		end else if (ctrl_wr_i) begin
			dn <= w & (lo == 4'hf) & (&d[7:6]);
			mn <= w & (lo == 4'h7) & d[4];
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_VEC: assert property (w && !d[0] |=>
		interrupt_vector_o == $past(d)) else $error("vector not stored");
	AST_MODE: assert property (w && lo == 4'hf |=>
		port_operating_mode_o == $past(d[7:6])) else $error("mode wrong");
	AST_DIR: assert property (ctrl_wr_i && dn |=>
		line_direction_o == $past(d)) else $error("direction wrong");
	AST_ICW: assert property (w && lo == 4'h7 |=>
		interrupt_condition_control_o == $past(d[6:5])
		&& int_enable_o == $past(d[7])) else $error("control wrong");
	AST_MASK: assert property (ctrl_wr_i && mn |=>
		interrupt_line_mask_o == $past(d) && $stable(int_enable_o))
		else $error("mask wrong");
	AST_EN: assert property (w && lo == 4'h3 |=>
		int_enable_o == $past(d[7]) && $stable(interrupt_line_mask_o)
		&& $stable(interrupt_condition_control_o))
		else $error("enable word wrong");
	AST_IGN: assert property (w && d[0] && lo != 4'hf && lo != 4'h7
		&& lo != 4'h3 |=> $stable(interrupt_vector_o)
		&& $stable(port_operating_mode_o) && $stable(int_enable_o))
		else $error("unknown word acted on");
	AST_PEND: assert property ($rose(int_pending_o) |->
		$past(port_operating_mode_o) == 2'h3 && $past(int_enable_o))
		else $error("request outside bit mode");
	AST_FALL: assert property ($fell(int_pending_o) |->
		$past(clr)) else $error("request dropped without clear");
	C_BIT: cover property (w && lo == 4'hf && (&d[7:6]));
	C_MSK: cover property (ctrl_wr_i && mn);
	C_REQ: cover property ($rose(int_pending_o));
endmodule
bind pio_port_control_word_decoder pio_port_control_word_decoder_asserts
	i_pio_port_control_word_decoder_asserts (
	.sys_clk_i                     (sys_clk_i),
	.rst_n_i                       (rst_n_i),
	.ctrl_wr_i                     (ctrl_wr_i),
	.ctrl_data_i                   (ctrl_data_i),
	.port_lines_i                  (port_lines_i),
	.int_clear_i                   (int_clear_i),
	.interrupt_vector_o            (interrupt_vector_o),
	.port_operating_mode_o         (port_operating_mode_o),
	.line_direction_o              (line_direction_o),
	.interrupt_condition_control_o (interrupt_condition_control_o),
	.interrupt_line_mask_o         (interrupt_line_mask_o),
	.int_enable_o                  (int_enable_o),
	.int_pending_o                 (int_pending_o)
);

// ---- dv/pio_port_control_word_decoder_tb.sv ----
// testbench for the control word decoder
`timescale 1ns/100ps
module pio_port_control_word_decoder_tb;
	logic       sys_clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       ctrl_wr_i;
	logic [7:0] ctrl_data_i;
	logic [7:0] port_lines_i = 8'h00;
	logic       int_clear_i = 1'b0;
	logic [7:0] interrupt_vector_o;
	logic [1:0] port_operating_mode_o;
	logic [7:0] line_direction_o;
	logic [1:0] interrupt_condition_control_o;
	logic [7:0] interrupt_line_mask_o;
	logic       int_enable_o;
	logic       int_pending_o;
	int         bad_count = 0;
	int         samples_checked = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	pio_host_model i_pio_host_model (.sys_clk_i(sys_clk_i),
		.ctrl_wr_o(ctrl_wr_i), .ctrl_data_o(ctrl_data_i));
	pio_port_control_word_decoder i_pio_port_control_word_decoder (
		.sys_clk_i                     (sys_clk_i),
		.rst_n_i                       (rst_n_i),
		.ctrl_wr_i                     (ctrl_wr_i),
		.ctrl_data_i                   (ctrl_data_i),
		.port_lines_i                  (port_lines_i),
		.int_clear_i                   (int_clear_i),
		.interrupt_vector_o            (interrupt_vector_o),
		.port_operating_mode_o         (port_operating_mode_o),
		.line_direction_o              (line_direction_o),
		.interrupt_condition_control_o (interrupt_condition_control_o),
		.interrupt_line_mask_o         (interrupt_line_mask_o),
		.int_enable_o                  (int_enable_o),
		.int_pending_o                 (int_pending_o)
	);
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task all(input logic [7:0] v, k, input logic [1:0] m, c, input logic e);
		chk("vector", interrupt_vector_o, v);
		chk("mode", {6'h00, port_operating_mode_o}, {6'h00, m});
		chk("direction", line_direction_o, 8'h62);
		chk("cond", {6'h00, interrupt_condition_control_o}, {6'h00, c});
		chk("mask", interrupt_line_mask_o, k);
		chk("enable", {7'h00, int_enable_o}, {7'h00, e});
	endtask
	task seq(input logic [7:0] q [$], input string t);
		foreach (q[i]) i_pio_host_model.send(q[i]);
		i_pio_host_model.idle;
		$display("test %s done", t);
	endtask
	task lines(input logic [7:0] l, input logic p);
		port_lines_i = l;
		repeat (3) @(negedge sys_clk_i);
		chk("pending", {7'h00, int_pending_o}, {7'h00, p});
	endtask
	task complete_run;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		chk("reset dir", line_direction_o, 8'hff);
		chk("reset mask", interrupt_line_mask_o, 8'hff);
		seq('{8'h02, 8'hcf, 8'h62, 8'hf7, 8'h9f}, "walk");
		all(8'h02, 8'h9f, 2'h3, 2'h3, 1'b1);
		lines(8'h40, 1'b0);
		lines(8'h60, 1'b1);
		port_lines_i = 8'h00;
		seq('{8'hb7, 8'h00}, "clear");
		all(8'h02, 8'h00, 2'h3, 2'h1, 1'b1);
		chk("cleared", {7'h00, int_pending_o}, 8'h00);
		lines(8'h80, 1'b0);
		lines(8'h02, 1'b1);
		int_clear_i = 1'b1;
		lines(8'h02, 1'b0);
		int_clear_i = 1'b0;
		seq('{8'h17, 8'h07, 8'h83}, "follow");
		all(8'h02, 8'h07, 2'h3, 2'h0, 1'b1);
		seq('{8'h05, 8'h0b, 8'h4f, 8'h44}, "other");
		all(8'h44, 8'h07, 2'h1, 2'h0, 1'b1);
		complete_run;
	end
endmodule
